// ---- cxe_pkg.sv ----
// Shared constants and types for the extended instruction execution core.
// Assumes a single clock domain and a decoded instruction stream from the fetch unit.
package cxe_pkg;

  typedef enum logic [3:0] {
    OP_NOP              = 4'h0,
    OP_ENTER_SLEEP      = 4'h1,
    OP_MULTIPLY         = 4'h2,
    OP_INPUT_IMM_PORT   = 4'h3,
    OP_OUTPUT_IMM_PORT  = 4'h4,
    OP_BLOCK_OUT_INC    = 4'h5,
    OP_BLOCK_OUT_INC_RP = 4'h6,
    OP_BLOCK_OUT_DEC    = 4'h7,
    OP_BLOCK_OUT_DEC_RP = 4'h8,
    OP_PORT_TEST        = 4'h9,
    OP_AND_TEST_REG     = 4'ha,
    OP_AND_TEST_IMM     = 4'hb,
    OP_AND_TEST_MEM     = 4'hc,
    OP_EXCHANGE_PAIRS   = 4'hd,
    OP_EXCHANGE_ACC     = 4'he
  } cxe_op_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_MEM_RD = 3'h1,
    S_IO_WR  = 3'h2,
    S_IO_RD  = 3'h3,
    S_MULT   = 3'h4,
    S_SLEEP  = 3'h5
  } cxe_state_t;

  // Byte register codes; code 6 stores the flag register
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_F = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;

  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_SP = 2'h3;

  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  IO_ADDR_HIGH = 8'h00;

  localparam logic [6:0]  FETCH_PLAIN    = 7'h01;
  localparam logic [6:0]  FETCH_PREFIXED = 7'h02;
  localparam logic [15:0] LEN_ONE        = 16'h0001;
  localparam logic [15:0] LEN_TWO        = 16'h0002;
  localparam logic [15:0] LEN_THREE      = 16'h0003;

endpackage

// ---- cxe_mult.sv ----
// Unsigned multiplier with a registered product, one cycle of latency.
// Assumes operands are stable in the cycle that i_start is high.
module cxe_mult #(
  parameter int WIDTH = 8
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_srst,
  input  wire logic               i_start,
  input  wire logic [WIDTH-1:0]   i_a,
  input  wire logic [WIDTH-1:0]   i_b,
  output logic                    o_done,
  output logic [2*WIDTH-1:0]      o_product
);

  if (WIDTH != 8) begin : g_bad_width
    $error("cxe_mult: the core serves only byte operands");
  end

  logic               done_r;
  logic               done_nxt;
  logic [2*WIDTH-1:0] prod_r;
  logic [2*WIDTH-1:0] prod_nxt;

  always_comb begin
    done_nxt = i_start;
    prod_nxt = prod_r;
    if (i_start) begin
      prod_nxt = {{WIDTH{1'b0}}, i_a} * {{WIDTH{1'b0}}, i_b};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      done_r <= 1'b0;
      prod_r <= '0;
    end else begin
      done_r <= done_nxt;
      prod_r <= prod_nxt;
    end
  end

  assign o_done    = done_r;
  assign o_product = prod_r;

endmodule

// ---- cxe_and_flags.sv ----
// Flag image of a logical AND of two bytes.
// Purely combinational; the caller decides when the flags are stored.
module cxe_and_flags (
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  output logic      [7:0] o_flags
);

  logic [7:0] result;

  always_comb begin
    result                    = i_a & i_b;
    o_flags                   = 8'h00;
    o_flags[cxe_pkg::FLAG_S]  = result[7];
    o_flags[cxe_pkg::FLAG_Z]  = (result == 8'h00);
    o_flags[cxe_pkg::FLAG_H]  = 1'b1;
    o_flags[cxe_pkg::FLAG_PV] = ~^result;
    o_flags[cxe_pkg::FLAG_N]  = 1'b0;
    o_flags[cxe_pkg::FLAG_C]  = 1'b0;
  end

endmodule

// ---- cxe_exec.sv ----
// Execution core for the extended instructions and the programmer register set.
// Assumes decoded instructions with a valid/ready handshake and a bus that acks each request.
// Contract
// - sleep op enters sleep and halts execution until woken.
// - multiply op forms unsigned product of pair halves into same pair.
// - block-out step reads memory at pointer pair, writes port at low count.
// - block-out steps pointer and port up or down; byte counter decrements.
// - repeating block-out loops until counter is zero; others do one step.
// - port accesses drive the upper address byte as zero.
// - port test ANDs port with immediate, sets flags, never writes port.
// - register test ANDs register with accumulator; both unchanged.
// - immediate test ANDs immediate with accumulator; accumulator unchanged.
// - memory test ANDs memory byte with accumulator; nothing else changes.
// - immediate input reads port at immediate address into named register.
// - immediate output writes named register to port at immediate address.
// - main set holds accumulator, flags and three splittable pairs.
// - hidden alternate set is swapped with the main set by exchanges.
// - special registers: vector base, refresh, two index, stack, program counter.
// - refresh low seven bits count opcode fetches; cleared at reset.
// - reset clears program counter and stack pointer.
// - zero flag follows a zero result, including test results.
module cxe_exec (
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  input  wire logic             i_op_valid,
  input  wire cxe_pkg::cxe_op_t i_op_code,
  input  wire logic [2:0]       i_op_reg,
  input  wire logic [1:0]       i_op_pair,
  input  wire logic [7:0]       i_op_imm,
  output logic                  o_op_ready,
  input  wire logic             i_wake_req,
  output logic                  o_sleep,
  output logic                  o_bus_req,
  output logic                  o_bus_wr,
  output logic                  o_bus_io,
  output logic      [15:0]      o_bus_addr,
  output logic      [7:0]       o_bus_wdata,
  input  wire logic             i_bus_ack,
  input  wire logic [7:0]       i_bus_rdata,
  output logic      [7:0]       o_acc,
  output logic      [7:0]       o_flags,
  output logic      [15:0]      o_bc,
  output logic      [15:0]      o_de,
  output logic      [15:0]      o_hl,
  output logic      [15:0]      o_ix,
  output logic      [15:0]      o_iy,
  output logic      [15:0]      o_sp,
  output logic      [15:0]      o_pc,
  output logic      [7:0]       o_vector_base,
  output logic      [7:0]       o_refresh
);

  cxe_pkg::cxe_state_t state_r;
  cxe_pkg::cxe_state_t state_nxt;
  cxe_pkg::cxe_op_t    op_r;
  cxe_pkg::cxe_op_t    op_nxt;
  logic [2:0]          sel_r;
  logic [2:0]          sel_nxt;
  logic [1:0]          pair_r;
  logic [1:0]          pair_nxt;
  logic [7:0]          imm_r;
  logic [7:0]          imm_nxt;
  logic [7:0][7:0]     main_r;
  logic [7:0][7:0]     main_nxt;
  logic [7:0][7:0]     alt_r;
  logic [7:0][7:0]     alt_nxt;
  logic [15:0]         sp_r;
  logic [15:0]         sp_nxt;
  logic [15:0]         pc_r;
  logic [15:0]         pc_nxt;
  logic [15:0]         ix_r;
  logic [15:0]         iy_r;
  logic [7:0]          vec_r;
  logic [7:0]          refr_r;
  logic [7:0]          refr_nxt;
  logic                req_r;
  logic                req_nxt;
  logic                wr_r;
  logic                wr_nxt;
  logic                io_r;
  logic                io_nxt;
  logic [15:0]         addr_r;
  logic [15:0]         addr_nxt;
  logic [7:0]          wdata_r;
  logic [7:0]          wdata_nxt;
  logic                ready_r;
  logic                ready_nxt;
  logic                sleep_r;
  logic                sleep_nxt;

  logic                accept;
  logic [15:0]         bc_w;
  logic [15:0]         hl_w;
  logic                blk_op;
  logic                blk_dec;
  logic                blk_rep;
  logic [15:0]         hl_step;
  logic [7:0]          c_step;
  logic [7:0]          b_dec;
  logic [7:0]          and_opnd;
  logic [7:0]          and_flags;
  logic                mult_start;
  logic [7:0]          mult_a;
  logic [7:0]          mult_b;
  logic                mult_done;
  logic [15:0]         mult_prod;

  function automatic logic [7:0] refresh_bump(input logic [7:0] r, input logic [6:0] n);
    return {r[7], r[6:0] + n};
  endfunction

  function automatic logic [6:0] fetch_count(input cxe_pkg::cxe_op_t op);
    if (op == cxe_pkg::OP_NOP || op == cxe_pkg::OP_EXCHANGE_PAIRS ||
        op == cxe_pkg::OP_EXCHANGE_ACC) begin
      return cxe_pkg::FETCH_PLAIN;
    end
    return cxe_pkg::FETCH_PREFIXED;
  endfunction

  function automatic logic [15:0] op_length(input cxe_pkg::cxe_op_t op);
    if (op == cxe_pkg::OP_NOP || op == cxe_pkg::OP_EXCHANGE_PAIRS ||
        op == cxe_pkg::OP_EXCHANGE_ACC) begin
      return cxe_pkg::LEN_ONE;
    end
    if (op == cxe_pkg::OP_INPUT_IMM_PORT || op == cxe_pkg::OP_OUTPUT_IMM_PORT ||
        op == cxe_pkg::OP_PORT_TEST || op == cxe_pkg::OP_AND_TEST_IMM) begin
      return cxe_pkg::LEN_THREE;
    end
    return cxe_pkg::LEN_TWO;
  endfunction

  assign accept  = i_op_valid && ready_r;
  assign bc_w    = {main_r[cxe_pkg::REG_B], main_r[cxe_pkg::REG_C]};
  assign hl_w    = {main_r[cxe_pkg::REG_H], main_r[cxe_pkg::REG_L]};
  assign blk_op  = op_r inside {cxe_pkg::OP_BLOCK_OUT_INC, cxe_pkg::OP_BLOCK_OUT_INC_RP,
                                cxe_pkg::OP_BLOCK_OUT_DEC, cxe_pkg::OP_BLOCK_OUT_DEC_RP};
  assign blk_dec = op_r inside {cxe_pkg::OP_BLOCK_OUT_DEC, cxe_pkg::OP_BLOCK_OUT_DEC_RP};
  assign blk_rep = op_r inside {cxe_pkg::OP_BLOCK_OUT_INC_RP, cxe_pkg::OP_BLOCK_OUT_DEC_RP};
  assign hl_step = blk_dec ? hl_w - 16'h0001 : hl_w + 16'h0001;
  assign c_step  = blk_dec ? main_r[cxe_pkg::REG_C] - 8'h01 : main_r[cxe_pkg::REG_C] + 8'h01;
  assign b_dec   = main_r[cxe_pkg::REG_B] - 8'h01;

  // Second AND operand depends on where the byte comes from
  always_comb begin
    unique case (state_r)
      cxe_pkg::S_MEM_RD: and_opnd = i_bus_rdata;
      cxe_pkg::S_IO_RD:  and_opnd = i_bus_rdata & imm_r;
      default:           and_opnd = (i_op_code == cxe_pkg::OP_AND_TEST_REG) ?
                                    main_r[i_op_reg] : i_op_imm;
    endcase
  end

  cxe_and_flags u_and_flags (
    .i_a     (state_r == cxe_pkg::S_IO_RD ? 8'hff : main_r[cxe_pkg::REG_A]),
    .i_b     (and_opnd),
    .o_flags (and_flags)
  );

  // Pair halves as multiplier operands
  always_comb begin
    unique case (i_op_pair)
      cxe_pkg::PAIR_BC: {mult_a, mult_b} = bc_w;
      cxe_pkg::PAIR_DE: {mult_a, mult_b} = {main_r[cxe_pkg::REG_D], main_r[cxe_pkg::REG_E]};
      cxe_pkg::PAIR_HL: {mult_a, mult_b} = hl_w;
      cxe_pkg::PAIR_SP: {mult_a, mult_b} = sp_r;
    endcase
  end

  cxe_mult #(
    .WIDTH (8)
  ) u_mult (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_start   (mult_start),
    .i_a       (mult_a),
    .i_b       (mult_b),
    .o_done    (mult_done),
    .o_product (mult_prod)
  );

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    sel_nxt   = sel_r;
    pair_nxt  = pair_r;
    imm_nxt   = imm_r;
    main_nxt  = main_r;
    alt_nxt   = alt_r;
    sp_nxt    = sp_r;
    pc_nxt    = pc_r;
    refr_nxt  = refr_r;
    req_nxt   = req_r;
    wr_nxt    = wr_r;
    io_nxt    = io_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    sleep_nxt = sleep_r;
    mult_start = 1'b0;
    unique case (state_r)
      cxe_pkg::S_IDLE: begin
        if (accept) begin
          op_nxt   = i_op_code;
          sel_nxt  = i_op_reg;
          pair_nxt = i_op_pair;
          imm_nxt  = i_op_imm;
          pc_nxt   = pc_r + op_length(i_op_code);
          refr_nxt = refresh_bump(refr_r, fetch_count(i_op_code));
          case (i_op_code)
            cxe_pkg::OP_ENTER_SLEEP: begin
              sleep_nxt = 1'b1;
              state_nxt = cxe_pkg::S_SLEEP;
            end
            cxe_pkg::OP_MULTIPLY: begin
              mult_start = 1'b1;
              state_nxt  = cxe_pkg::S_MULT;
            end
            cxe_pkg::OP_INPUT_IMM_PORT, cxe_pkg::OP_OUTPUT_IMM_PORT: begin
              req_nxt   = 1'b1;
              io_nxt    = 1'b1;
              wr_nxt    = (i_op_code == cxe_pkg::OP_OUTPUT_IMM_PORT);
              addr_nxt  = {cxe_pkg::IO_ADDR_HIGH, i_op_imm};
              wdata_nxt = main_r[i_op_reg];
              state_nxt = wr_nxt ? cxe_pkg::S_IO_WR : cxe_pkg::S_IO_RD;
            end
            cxe_pkg::OP_PORT_TEST: begin
              req_nxt   = 1'b1;
              io_nxt    = 1'b1;
              wr_nxt    = 1'b0;
              addr_nxt  = {cxe_pkg::IO_ADDR_HIGH, main_r[cxe_pkg::REG_C]};
              state_nxt = cxe_pkg::S_IO_RD;
            end
            cxe_pkg::OP_BLOCK_OUT_INC, cxe_pkg::OP_BLOCK_OUT_INC_RP,
            cxe_pkg::OP_BLOCK_OUT_DEC, cxe_pkg::OP_BLOCK_OUT_DEC_RP,
            cxe_pkg::OP_AND_TEST_MEM: begin
              req_nxt   = 1'b1;
              io_nxt    = 1'b0;
              wr_nxt    = 1'b0;
              addr_nxt  = hl_w;
              state_nxt = cxe_pkg::S_MEM_RD;
            end
            cxe_pkg::OP_AND_TEST_REG, cxe_pkg::OP_AND_TEST_IMM: begin
              main_nxt[cxe_pkg::REG_F] = and_flags;
            end
            cxe_pkg::OP_EXCHANGE_PAIRS, cxe_pkg::OP_EXCHANGE_ACC: begin
              for (int i = 0; i < 8; i++) begin
                if ((i >= 6) == (i_op_code == cxe_pkg::OP_EXCHANGE_ACC)) begin
                  main_nxt[i] = alt_r[i];
                  alt_nxt[i]  = main_r[i];
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      cxe_pkg::S_MEM_RD: begin
        if (i_bus_ack) begin
          if (blk_op) begin
            wr_nxt    = 1'b1;
            io_nxt    = 1'b1;
            addr_nxt  = {cxe_pkg::IO_ADDR_HIGH, main_r[cxe_pkg::REG_C]};
            wdata_nxt = i_bus_rdata;
            state_nxt = cxe_pkg::S_IO_WR;
          end else begin
            main_nxt[cxe_pkg::REG_F] = and_flags;
            req_nxt   = 1'b0;
            state_nxt = cxe_pkg::S_IDLE;
          end
        end
      end
      cxe_pkg::S_IO_WR: begin
        if (i_bus_ack) begin
          req_nxt   = 1'b0;
          wr_nxt    = 1'b0;
          state_nxt = cxe_pkg::S_IDLE;
          if (blk_op) begin
            {main_nxt[cxe_pkg::REG_H], main_nxt[cxe_pkg::REG_L]} = hl_step;
            main_nxt[cxe_pkg::REG_C] = c_step;
            main_nxt[cxe_pkg::REG_B] = b_dec;
            main_nxt[cxe_pkg::REG_F][cxe_pkg::FLAG_Z] = (b_dec == 8'h00);
            if (blk_rep && b_dec != 8'h00) begin
              req_nxt   = 1'b1;
              io_nxt    = 1'b0;
              addr_nxt  = hl_step;
              refr_nxt  = refresh_bump(refr_r, cxe_pkg::FETCH_PREFIXED);
              state_nxt = cxe_pkg::S_MEM_RD;
            end
          end
        end
      end
      cxe_pkg::S_IO_RD: begin
        if (i_bus_ack) begin
          if (op_r == cxe_pkg::OP_PORT_TEST) begin
            main_nxt[cxe_pkg::REG_F] = and_flags;
          end else begin
            main_nxt[sel_r] = i_bus_rdata;
          end
          req_nxt   = 1'b0;
          state_nxt = cxe_pkg::S_IDLE;
        end
      end
      cxe_pkg::S_MULT: begin
        if (mult_done) begin
          unique case (pair_r)
            cxe_pkg::PAIR_BC: {main_nxt[cxe_pkg::REG_B], main_nxt[cxe_pkg::REG_C]} = mult_prod;
            cxe_pkg::PAIR_DE: {main_nxt[cxe_pkg::REG_D], main_nxt[cxe_pkg::REG_E]} = mult_prod;
            cxe_pkg::PAIR_HL: {main_nxt[cxe_pkg::REG_H], main_nxt[cxe_pkg::REG_L]} = mult_prod;
            cxe_pkg::PAIR_SP: sp_nxt = mult_prod;
          endcase
          state_nxt = cxe_pkg::S_IDLE;
        end
      end
      cxe_pkg::S_SLEEP: begin
        if (i_wake_req) begin
          sleep_nxt = 1'b0;
          state_nxt = cxe_pkg::S_IDLE;
        end
      end
      default: begin
        state_nxt = cxe_pkg::S_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == cxe_pkg::S_IDLE) && !accept;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= cxe_pkg::S_IDLE;
      op_r    <= cxe_pkg::OP_NOP;
      sel_r   <= cxe_pkg::REG_B;
      pair_r  <= cxe_pkg::PAIR_BC;
      imm_r   <= cxe_pkg::RST_BYTE;
      main_r  <= '0;
      alt_r   <= '0;
      sp_r    <= cxe_pkg::RST_WORD;
      pc_r    <= cxe_pkg::RST_WORD;
      ix_r    <= cxe_pkg::RST_WORD;
      iy_r    <= cxe_pkg::RST_WORD;
      vec_r   <= cxe_pkg::RST_BYTE;
      refr_r  <= cxe_pkg::RST_BYTE;
      req_r   <= 1'b0;
      wr_r    <= 1'b0;
      io_r    <= 1'b0;
      addr_r  <= cxe_pkg::RST_WORD;
      wdata_r <= cxe_pkg::RST_BYTE;
      ready_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      sel_r   <= sel_nxt;
      pair_r  <= pair_nxt;
      imm_r   <= imm_nxt;
      main_r  <= main_nxt;
      alt_r   <= alt_nxt;
      sp_r    <= sp_nxt;
      pc_r    <= pc_nxt;
      refr_r  <= refr_nxt;
      req_r   <= req_nxt;
      wr_r    <= wr_nxt;
      io_r    <= io_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      ready_r <= ready_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  assign o_op_ready    = ready_r;
  assign o_sleep       = sleep_r;
  assign o_bus_req     = req_r;
  assign o_bus_wr      = wr_r;
  assign o_bus_io      = io_r;
  assign o_bus_addr    = addr_r;
  assign o_bus_wdata   = wdata_r;
  assign o_acc         = main_r[cxe_pkg::REG_A];
  assign o_flags       = main_r[cxe_pkg::REG_F];
  assign o_bc          = bc_w;
  assign o_de          = {main_r[cxe_pkg::REG_D], main_r[cxe_pkg::REG_E]};
  assign o_hl          = hl_w;
  assign o_ix          = ix_r;
  assign o_iy          = iy_r;
  assign o_sp          = sp_r;
  assign o_pc          = pc_r;
  assign o_vector_base = vec_r;
  assign o_refresh     = refr_r;

  // Checks
  logic [15:0] mul_ref_bc;
  logic [7:0]  sel_byte;
  logic [7:0]  reg_and;
  logic [6:0]  fetch_inc;
  assign mul_ref_bc = 16'(main_r[cxe_pkg::REG_B]) * 16'(main_r[cxe_pkg::REG_C]);
  assign sel_byte   = main_r[i_op_reg];
  assign reg_and    = sel_byte & main_r[cxe_pkg::REG_A];
  assign fetch_inc  = fetch_count(i_op_code);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sleep_entry_a: assert property (accept && i_op_code == cxe_pkg::OP_ENTER_SLEEP |=>
    (o_sleep && !o_op_ready) until i_wake_req) else $error("sleep not held");
  sleep_exit_a: assert property (o_sleep && i_wake_req |=> !o_sleep ##1 o_op_ready)
    else $error("sleep exit wrong");
  mult_bc_a: assert property (accept && i_op_code == cxe_pkg::OP_MULTIPLY &&
    i_op_pair == cxe_pkg::PAIR_BC |-> ##2 o_bc == $past(mul_ref_bc, 2))
    else $error("multiply product wrong");
  blk_write_a: assert property (state_r == cxe_pkg::S_MEM_RD && blk_op && i_bus_ack |=>
    o_bus_req && o_bus_wr && o_bus_io && o_bus_addr[7:0] == $past(o_bc[7:0]) &&
    o_bus_wdata == $past(i_bus_rdata)) else $error("block write wrong");
  blk_step_a: assert property (state_r == cxe_pkg::S_IO_WR && blk_op && !blk_dec &&
    i_bus_ack |=> o_hl == $past(o_hl) + 16'h0001 && o_bc[15:8] == $past(o_bc[15:8]) - 8'h01)
    else $error("block step wrong");
  blk_loop_a: assert property (state_r == cxe_pkg::S_IO_WR && blk_op && i_bus_ack |=>
    (state_r == cxe_pkg::S_MEM_RD) == ($past(blk_rep) && o_bc[15:8] != 8'h00))
    else $error("block repeat wrong");
  io_high_a: assert property (o_bus_req && o_bus_io |-> o_bus_addr[15:8] == 8'h00)
    else $error("io high address not zero");
  port_test_a: assert property (state_r == cxe_pkg::S_IO_RD && op_r == cxe_pkg::OP_PORT_TEST
    && i_bus_ack |=> !o_bus_req && o_flags[6] == (($past(i_bus_rdata) & $past(imm_r)) == 0))
    else $error("port test wrong");
  reg_test_a: assert property (accept && i_op_code == cxe_pkg::OP_AND_TEST_REG |=>
    o_acc == $past(o_acc) && o_flags[6] == ($past(reg_and) == 8'h00))
    else $error("register test wrong");
  imm_test_a: assert property (accept && i_op_code == cxe_pkg::OP_AND_TEST_IMM |=>
    o_acc == $past(o_acc) && o_flags[7] == ($past(o_acc[7]) & $past(i_op_imm[7])))
    else $error("immediate test wrong");
  mem_test_a: assert property (accept && i_op_code == cxe_pkg::OP_AND_TEST_MEM |=>
    o_bus_req && !o_bus_wr && !o_bus_io && o_bus_addr == $past(o_hl))
    else $error("memory test wrong");
  in_imm_a: assert property (accept && i_op_code == cxe_pkg::OP_INPUT_IMM_PORT |=>
    o_bus_req && !o_bus_wr && o_bus_io && o_bus_addr[7:0] == $past(i_op_imm))
    else $error("immediate input wrong");
  out_imm_a: assert property (accept && i_op_code == cxe_pkg::OP_OUTPUT_IMM_PORT |=>
    o_bus_wr && o_bus_wdata == $past(sel_byte)) else $error("immediate output wrong");
  swap_pairs_a: assert property (accept && i_op_code == cxe_pkg::OP_EXCHANGE_PAIRS |=>
    o_bc == {$past(alt_r[0]), $past(alt_r[1])} && o_acc == $past(o_acc))
    else $error("exchange wrong");
  refresh_a: assert property (accept |=> o_refresh[6:0] ==
    $past(o_refresh[6:0]) + $past(fetch_inc) && o_refresh[7] == $past(o_refresh[7]))
    else $error("refresh count wrong");
  reset_clear_a: assert property (disable iff (1'b0) i_srst |=>
    o_pc == 16'h0000 && o_sp == 16'h0000 && o_refresh == 8'h00) else $error("reset values wrong");

  sleep_c: cover property (o_sleep ##1 !o_sleep);
  blk_loop_c: cover property (state_r == cxe_pkg::S_IO_WR && blk_rep && i_bus_ack ##1
    state_r == cxe_pkg::S_MEM_RD);
  mult_c: cover property (state_r == cxe_pkg::S_MULT && mult_done);
  port_test_c: cover property (state_r == cxe_pkg::S_IO_RD && op_r == cxe_pkg::OP_PORT_TEST &&
    i_bus_ack);

endmodule

// ---- cxe_bus_model.sv ----
// Memory and I/O space model answering the core's bus requests.
// Assumes requests hold until ack; answers after 0 or 2 wait cycles.
module cxe_bus_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_io,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_wdata,
  output logic             o_bus_ack,
  output logic      [7:0]  o_bus_rdata,
  output logic      [15:0] o_wr_addr,
  output logic      [7:0]  o_wr_data,
  output logic      [7:0]  o_wr_cnt,
  output logic             o_hi_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wt = 2'h0;
  initial begin
    {o_bus_ack, o_bus_rdata, o_wr_addr, o_wr_data, o_wr_cnt, o_hi_bad} = 42'h0;
  end
  always @(posedge i_ref_clk) begin
    o_bus_ack <= 1'b0;
    // Idle data keeps changing
    o_bus_rdata <= o_bus_rdata + 8'h35;
    if (i_bus_req && !o_bus_ack) begin
      if (wt != 2'h0) begin
        wt <= wt - 2'h1;
      end else begin
        o_bus_ack <= 1'b1;
        o_bus_rdata <= i_bus_io ? i_bus_addr[7:0] ^ 8'h5a : i_bus_addr[7:0] + 8'h11;
        wt <= {o_wr_cnt[0], 1'b0};
        if (i_bus_io && i_bus_addr[15:8] != 8'h00) o_hi_bad <= 1'b1;
        if (i_bus_wr) begin
          o_wr_addr <= i_bus_addr;
          o_wr_data <= i_bus_wdata;
          o_wr_cnt <= o_wr_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// ---- cpu_extended_instruction_exec_tb.sv ----
// Self-checking bench for the extended instruction core.
// Assumes cxe_bus_model answers every bus request.
module cpu_extended_instruction_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, wake = 1'b0, rdy_q = 1'b0;
  logic ack, rdy, enter_sleep_op, req, wr, io, hib;
  cxe_pkg::cxe_op_t code = cxe_pkg::OP_NOP;
  logic [2:0] rg = 3'h0;
  logic [1:0] pr = 2'h0;
  logic [7:0] imm = 8'h00, rdat, wdat, acc, flg, wda, wcnt, rf, vb, a = 8'h00, f = 8'h00, m, k, n;
  logic [15:0] adr, bc, de, hl, ix, iy, sp, pc, wad, b = 16'h0, d = 16'h0, h = 16'h0, wa;
  logic [15:0] xa = 16'h0;
  logic [47:0] xp = 48'h0;
  logic [2:0] rc[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [63:0] exp_q[$];
  int num_errors = 0, n_tests = 0, cyc = 0;
  integer seed = 32'h4c4992fc;
  always #4 clk = ~clk;
  cxe_exec u_cxe_exec (.i_ref_clk(clk), .i_srst(rst), .i_op_valid(vld), .i_op_code(code),
    .i_op_reg(rg), .i_op_pair(pr), .i_op_imm(imm), .o_op_ready(rdy), .i_wake_req(wake),
    .o_sleep(enter_sleep_op), .o_bus_req(req), .o_bus_wr(wr), .o_bus_io(io), .o_bus_addr(adr),
    .o_bus_wdata(wdat), .i_bus_ack(ack), .i_bus_rdata(rdat), .o_acc(acc), .o_flags(flg),
    .o_bc(bc), .o_de(de), .o_hl(hl), .o_ix(ix), .o_iy(iy), .o_sp(sp), .o_pc(pc),
    .o_vector_base(vb), .o_refresh(rf));
  cxe_bus_model u_cxe_bus_model (.i_ref_clk(clk), .i_bus_req(req), .i_bus_wr(wr),
    .i_bus_io(io), .i_bus_addr(adr), .i_bus_wdata(wdat), .o_bus_ack(ack),
    .o_bus_rdata(rdat), .o_wr_addr(wad), .o_wr_data(wda), .o_wr_cnt(wcnt), .o_hi_bad(hib));
  task automatic chk(input logic [63:0] s, input logic [63:0] e, input string nm);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] andf(input logic [7:0] r);
    return {r[7], r == 8'h00, 2'b01, 1'b0, ~^r, 2'b00};
  endfunction
  task automatic op(input cxe_pkg::cxe_op_t c, input logic [2:0] r, input logic [1:0] p,
                    input logic [7:0] v);
    vld <= 1'b1; code <= c; rg <= r; pr <= p; imm <= v;
    exp_q.push_back({a, f, b, d, h});
    do @(posedge clk); while (rdy !== 1'b1);
    vld <= 1'b0;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Result watcher: one note per completed instruction
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      end_sim();
    end
    if (rdy === 1'b1 && rdy_q === 1'b0 && exp_q.size() > 0) begin
      chk({acc, flg, bc, de, hl}, exp_q.pop_front(), "state");
    end
    rdy_q <= rdy;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({rf, sp, pc}, 64'h0, "reset regs");
    chk({ix, iy, vb}, 64'h0, "special regs");
    for (int i = 0; i < 7; i++) begin
      m = (i == 0) ? 8'h58 : 8'($random(seed));
      case (i)
        0: b[15:8] = m ^ 8'h5a;
        1: b[7:0] = m ^ 8'h5a;
        2: d[15:8] = m ^ 8'h5a;
        3: d[7:0] = m ^ 8'h5a;
        4: h[15:8] = m ^ 8'h5a;
        5: h[7:0] = m ^ 8'h5a;
        default: a = m ^ 8'h5a;
      endcase
      op(cxe_pkg::OP_INPUT_IMM_PORT, rc[i], 2'h0, m);
    end
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 8'h00 : 8'($random(seed));
      f = andf(a & m);
      op(cxe_pkg::OP_AND_TEST_IMM, 3'h0, 2'h0, m);
    end
    f = andf(a & b[15:8]);
    op(cxe_pkg::OP_AND_TEST_REG, 3'h0, 2'h0, 8'h00);
    f = andf(a & (h[7:0] + 8'h11));
    op(cxe_pkg::OP_AND_TEST_MEM, 3'h0, 2'h0, 8'h00);
    m = 8'($random(seed));
    k = wcnt;
    f = andf((b[7:0] ^ 8'h5a) & m);
    op(cxe_pkg::OP_PORT_TEST, 3'h0, 2'h0, m);
    chk(wcnt, k, "no port write");
    op(cxe_pkg::OP_OUTPUT_IMM_PORT, 3'h7, 2'h0, m);
    chk({wad, wda}, {8'h00, m, a}, "out write");
    $display("Tests and port access done");
    for (int j = 0; j < 2; j++) begin
      k = wcnt;
      n = (j == 0) ? b[15:8] : 8'h01;
      for (int s = 0; s < n; s++) begin
        wa = {8'h00, b[7:0]};
        m = h[7:0] + 8'h11;
        h = (j == 0) ? h + 16'h1 : h - 16'h1;
        b[7:0] = (j == 0) ? b[7:0] + 8'h1 : b[7:0] - 8'h1;
        b[15:8] = b[15:8] - 8'h1;
        f[6] = b[15:8] == 8'h00;
      end
      op(j == 0 ? cxe_pkg::OP_BLOCK_OUT_INC_RP : cxe_pkg::OP_BLOCK_OUT_DEC, 3'h0, 2'h0, 8'h00);
      chk({wad, wda, wcnt}, {wa, m, k + n}, "block out");
    end
    h = {8'h00, h[15:8]} * {8'h00, h[7:0]};
    op(cxe_pkg::OP_MULTIPLY, 3'h0, cxe_pkg::PAIR_HL, 8'h00);
    b = {8'h00, b[15:8]} * {8'h00, b[7:0]};
    op(cxe_pkg::OP_MULTIPLY, 3'h0, cxe_pkg::PAIR_BC, 8'h00);
    for (int j = 0; j < 4; j++) begin
      if (j % 2) {a, f, xa} = {xa, a, f};
      else {b, d, h, xp} = {xp, b, d, h};
      op(j % 2 ? cxe_pkg::OP_EXCHANGE_ACC : cxe_pkg::OP_EXCHANGE_PAIRS, 3'h0, 2'h0,
         8'h00);
    end
    $display("Block and multiply done");
    fork
      op(cxe_pkg::OP_ENTER_SLEEP, 3'h0, 2'h0, 8'h00);
      begin
        repeat (6) @(posedge clk);
        chk({enter_sleep_op, rdy}, 2'b10, "sleep");
        wake <= 1'b1;
      end
    join
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk(hib, 1'b0, "io high byte");
    $display("Sleep done");
    end_sim();
  end
endmodule
